/* File: pdg_ctrl.sv */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module pdg_ctrl #(
	parameter bit FIRST = 1'b1
) (
	input wire logic I_REF_CLK, // oscillator reference clock
	input wire logic I_RST_N, // async chip reset, low
	input wire logic [7:0] I_AXI_AWADDR, // write address
	input wire logic I_AXI_AWVALID, // write address valid
	output logic O_AXI_AWREADY, // write address ready
	input wire logic [31:0] I_AXI_WDATA, // write data
	input wire logic [3:0] I_AXI_WSTRB, // write strobes
	input wire logic I_AXI_WVALID, // write data valid
	output logic O_AXI_WREADY, // write data ready
	output logic [1:0] O_AXI_BRESP, // write response
	output logic O_AXI_BVALID, // write response valid
	input wire logic I_AXI_BREADY, // write response ready
	input wire logic [7:0] I_AXI_ARADDR, // read address
	input wire logic I_AXI_ARVALID, // read address valid
	output logic O_AXI_ARREADY, // read address ready
	output logic [31:0] O_AXI_RDATA, // read data
	output logic [1:0] O_AXI_RRESP, // read response
	output logic O_AXI_RVALID, // read data valid
	input wire logic I_AXI_RREADY, // read data ready
	input wire logic I_PLL_LOCK, // pll core locked
	input wire logic I_OSC_COUNTING, // reset clock counter busy
	input wire logic [8:0] I_SYS_RUNNING, // external system clocks on
	input wire logic [8:0] I_RATIO_PENDING, // external dividers differ
	output logic O_BYPASS_CLK_EN, // bypass system clock tick
	output logic O_POST_CLK_EN, // post divider tick
	output logic O_SYS_FOUR_CLK_EN, // system clock 4 tick
	output logic O_OBS_CLK_GATE, // observation clock enable
	output logic O_AUX_CLK_GATE, // auxiliary clock enable
	output logic [8:0] O_ALIGN_PULSE, // apply and align, one cycle
	output logic O_GO_BUSY // go operation in progress
);
	localparam logic [8:0] ALIGN_MASK = FIRST ? 9'h1ff : 9'h01f;
	localparam logic [8:0] ALIGN_RST =
		FIRST ? pdg_pkg::ALIGN_RST_FIRST : pdg_pkg::ALIGN_RST_SECOND;

	function automatic logic is_reg(input logic [7:0] a,
		input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction : is_reg

	pdg_pkg::pdg_div_type post_div;
	pdg_pkg::pdg_div_type bypass_div;
	pdg_pkg::pdg_div_type four_div;
	pdg_pkg::pdg_div_type four_applied;
	pdg_pkg::pdg_clk_en_type clk_en;
	pdg_pkg::pdg_go_state_type go_state;
	logic go_trigger;
	logic go_start;
	logic [8:0] align_sel;
	logic [8:0] ratio_changed;
	logic stable;
	logic lock;
	logic [3:0] clk_on;
	logic [8:0] sys_on;
	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic [4:0] cnt [3];
	logic [4:0] ratio_of [3];
	logic [2:0] tick;
	logic [2:0] enab;
	logic [2:0] restart;

	// write: address and data taken together in one cycle
	assign wr_fire = I_AXI_AWVALID && I_AXI_WVALID && !O_AXI_AWREADY &&
		!O_AXI_BVALID;
	assign wr_addr = I_AXI_AWADDR;
	assign wr_data = I_AXI_WDATA;

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			O_AXI_AWREADY <= 1'b0;
			O_AXI_WREADY <= 1'b0;
			O_AXI_BVALID <= 1'b0;
			O_AXI_BRESP <= pdg_pkg::RESP_OKAY;
		end
		else
		begin
			O_AXI_AWREADY <= wr_fire;
			O_AXI_WREADY <= wr_fire;
			if (wr_fire)
				O_AXI_BRESP <= (is_reg(wr_addr, pdg_pkg::OFF_CLK_EN) &&
					!FIRST) || next_rerr_w(wr_addr) ?
					pdg_pkg::RESP_SLVERR : pdg_pkg::RESP_OKAY;
			// response only after both channels have handshaken
			if (O_AXI_AWREADY)
				O_AXI_BVALID <= 1'b1;
			else if (I_AXI_BREADY)
				O_AXI_BVALID <= 1'b0;
		end
	end

	function automatic logic next_rerr_w(input logic [7:0] a);
		return a > pdg_pkg::OFF_DIV_FOUR + 8'h03;
	endfunction : next_rerr_w

	// byte lanes 0 and 1 carry the writable fields, all below bit 16
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			post_div <= pdg_pkg::DIV_RST;
			bypass_div <= pdg_pkg::DIV_RST;
			four_div <= pdg_pkg::DIV_RST;
			align_sel <= ALIGN_RST;
			clk_en <= '{obs_en: 1'b0, aux_en: FIRST};
		end
		else if (wr_fire)
		begin
			if (is_reg(wr_addr, pdg_pkg::OFF_POST_DIV))
			begin
				if (I_AXI_WSTRB[0])
					post_div.ratio <= wr_data[4:0];
				if (I_AXI_WSTRB[1])
					post_div.en <= wr_data[pdg_pkg::DIV_EN_BIT];
			end
			if (is_reg(wr_addr, pdg_pkg::OFF_BYPASS_DIV))
			begin
				if (I_AXI_WSTRB[0])
					bypass_div.ratio <= wr_data[4:0];
				if (I_AXI_WSTRB[1])
					bypass_div.en <= wr_data[pdg_pkg::DIV_EN_BIT];
			end
			if (is_reg(wr_addr, pdg_pkg::OFF_DIV_FOUR))
			begin
				if (I_AXI_WSTRB[0])
					four_div.ratio <= wr_data[4:0];
				if (I_AXI_WSTRB[1])
					four_div.en <= wr_data[pdg_pkg::DIV_EN_BIT];
			end
			if (is_reg(wr_addr, pdg_pkg::OFF_ALIGN_SEL))
			begin
				if (I_AXI_WSTRB[0])
					align_sel[7:0] <= wr_data[7:0] & ALIGN_MASK[7:0];
				if (I_AXI_WSTRB[1])
					align_sel[8] <= wr_data[8] & ALIGN_MASK[8];
			end
			if (is_reg(wr_addr, pdg_pkg::OFF_CLK_EN) && FIRST &&
				I_AXI_WSTRB[0])
				clk_en <= wr_data[1:0];
		end
	end

	// go trigger holds its value; a one-write while idle launches a go
	assign go_start = wr_fire && is_reg(wr_addr, pdg_pkg::OFF_GO_CMD) &&
		I_AXI_WSTRB[0] && wr_data[0] && go_state == pdg_pkg::GO_IDLE;

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			go_trigger <= 1'b0;
		else if (wr_fire && is_reg(wr_addr, pdg_pkg::OFF_GO_CMD) &&
			I_AXI_WSTRB[0])
			go_trigger <= wr_data[0];
	end

	// a one-write during a running go is dropped, software must poll
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			go_state <= pdg_pkg::GO_IDLE;
			four_applied <= pdg_pkg::DIV_RST;
			ratio_changed <= 9'h000;
			O_ALIGN_PULSE <= 9'h000;
			O_GO_BUSY <= 1'b0;
		end
		else
		begin
			O_ALIGN_PULSE <= 9'h000;
			case (go_state)
				pdg_pkg::GO_IDLE:
				begin
					if (go_start)
					begin
						go_state <= pdg_pkg::GO_WAIT;
						O_GO_BUSY <= 1'b1;
						ratio_changed <= (I_RATIO_PENDING & ~9'h008 |
							{5'h00, four_div != four_applied, 3'h0}) &
							ALIGN_MASK;
					end
				end
				pdg_pkg::GO_WAIT:
				begin
					// switch on a period boundary to avoid a runt tick
					if (tick[2] || !four_applied.en)
						go_state <= pdg_pkg::GO_APPLY;
				end
				pdg_pkg::GO_APPLY:
				begin
					four_applied <= four_div;
					O_ALIGN_PULSE <= align_sel;
					O_GO_BUSY <= 1'b0;
					go_state <= pdg_pkg::GO_IDLE;
				end
				default:
				begin
					go_state <= pdg_pkg::GO_IDLE;
					O_GO_BUSY <= 1'b0;
				end
			endcase
		end
	end

	// dividers: 0 bypass, 1 post, 2 system clock 4
	assign ratio_of[0] = bypass_div.ratio;
	assign ratio_of[1] = post_div.ratio;
	assign ratio_of[2] = four_applied.ratio;
	assign enab = {four_applied.en, post_div.en, bypass_div.en};
	assign restart = {go_state == pdg_pkg::GO_APPLY &&
		align_sel[pdg_pkg::SYS_FOUR_IDX], 2'b00};

	for (genvar g = 0; g < 3; g++)
	begin : g_div
		assign tick[g] = enab[g] && cnt[g] >= ratio_of[g];
		always_ff @(posedge I_REF_CLK or negedge I_RST_N)
		begin
			if (!I_RST_N)
				cnt[g] <= 5'h00;
			else if (restart[g] || tick[g] || !enab[g])
				cnt[g] <= 5'h00;
			else
				cnt[g] <= cnt[g] + 5'h01;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			O_BYPASS_CLK_EN <= 1'b0;
			O_POST_CLK_EN <= 1'b0;
			O_SYS_FOUR_CLK_EN <= 1'b0;
			O_OBS_CLK_GATE <= 1'b0;
			O_AUX_CLK_GATE <= FIRST;
		end
		else
		begin
			O_BYPASS_CLK_EN <= tick[0];
			O_POST_CLK_EN <= tick[1];
			O_SYS_FOUR_CLK_EN <= tick[2];
			O_OBS_CLK_GATE <= clk_en.obs_en;
			O_AUX_CLK_GATE <= clk_en.aux_en && FIRST;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			stable <= 1'b1;
			lock <= 1'b0;
			clk_on <= {1'b1, 2'b00, FIRST};
			sys_on <= 9'h000;
		end
		else
		begin
			stable <= !I_OSC_COUNTING;
			lock <= I_PLL_LOCK;
			clk_on <= {bypass_div.en, 1'b0, O_OBS_CLK_GATE,
				O_AUX_CLK_GATE};
			sys_on <= {I_SYS_RUNNING[8:4], four_applied.en,
				I_SYS_RUNNING[2:0]} & ALIGN_MASK;
		end
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_POST_DIV))
			next_rdata = {16'h0000, post_div.en, 10'h000, post_div.ratio};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_BYPASS_DIV))
			next_rdata = {16'h0000, bypass_div.en, 10'h000,
				bypass_div.ratio};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_GO_CMD))
			next_rdata = {31'h0000_0000, go_trigger};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_CTRL_STAT))
			next_rdata = {29'h0000_0000, stable, lock, O_GO_BUSY};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_ALIGN_SEL))
			next_rdata = {23'h00_0000, align_sel};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_RATIO_CHG))
			next_rdata = {23'h00_0000, ratio_changed};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_CLK_EN))
		begin
			next_rdata = {30'h0000_0000, clk_en};
			next_rerr = !FIRST;
		end
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_CLK_ON))
			next_rdata = {28'h000_0000, clk_on};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_OUT_STAT))
			next_rdata = {23'h00_0000, sys_on};
		else if (is_reg(I_AXI_ARADDR, pdg_pkg::OFF_DIV_FOUR))
			next_rdata = {16'h0000, four_div.en, 10'h000, four_div.ratio};
		else
			next_rerr = 1'b1;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			O_AXI_ARREADY <= 1'b0;
			O_AXI_RVALID <= 1'b0;
			O_AXI_RDATA <= 32'h0000_0000;
			O_AXI_RRESP <= pdg_pkg::RESP_OKAY;
		end
		else
		begin
			O_AXI_ARREADY <= I_AXI_ARVALID && !O_AXI_ARREADY &&
				!O_AXI_RVALID;
			if (I_AXI_ARVALID && !O_AXI_ARREADY && !O_AXI_RVALID)
			begin
				O_AXI_RDATA <= next_rerr ? 32'h0000_0000 : next_rdata;
				O_AXI_RRESP <= next_rerr ? pdg_pkg::RESP_SLVERR :
					pdg_pkg::RESP_OKAY;
			end
			if (O_AXI_ARREADY)
				O_AXI_RVALID <= 1'b1;
			else if (I_AXI_RREADY)
				O_AXI_RVALID <= 1'b0;
		end
	end

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	chk_go_starts: assert property (go_start |=> O_GO_BUSY ##1 O_GO_BUSY)
		else $error("go did not start");
	chk_trigger_hold: assert property (go_trigger && !(wr_fire &&
		is_reg(wr_addr, pdg_pkg::OFF_GO_CMD) && I_AXI_WSTRB[0])
		|=> go_trigger)
		else $error("go trigger lost");
	chk_busy_bound: assert property ($rose(O_GO_BUSY) |->
		##[1:36] !O_GO_BUSY)
		else $error("go never finished");
	chk_busy_end: assert property ($fell(O_GO_BUSY) |->
		$past(go_state) == pdg_pkg::GO_APPLY && four_applied == $past(four_div))
		else $error("go ended before apply");
	chk_stable_flag: assert property (##1 stable == !$past(I_OSC_COUNTING))
		else $error("stable flag wrong");
	chk_lock_flag: assert property (##1 lock == $past(I_PLL_LOCK))
		else $error("lock flag wrong");
	chk_align_restart: assert property (go_state == pdg_pkg::GO_APPLY &&
		align_sel[3] |=> cnt[2] == 5'h00 && O_ALIGN_PULSE == $past(align_sel))
		else $error("alignment not applied");
	chk_ratio_flag: assert property (go_start |=> ratio_changed[3] ==
		$past(four_div != four_applied))
		else $error("ratio flag wrong");
	chk_second_res: assert property (!FIRST |-> ratio_changed[8:5] == 4'h0
		&& sys_on[8:5] == 4'h0 && !O_AUX_CLK_GATE)
		else $error("reserved bits set");
	chk_div_period: assert property (tick[2] && !restart[2] |=>
		cnt[2] == 5'h00 && (four_applied.ratio == 5'h00 || !tick[2]))
		else $error("divider period wrong");
	chk_bypass_on: assert property (##1 clk_on[3] == $past(bypass_div.en))
		else $error("bypass status wrong");

	cov_go_done: cover property ($rose(O_GO_BUSY) ##[1:36] $fell(O_GO_BUSY));
	cov_ratio_mod: cover property (go_start ##1 ratio_changed[3]);
	cov_read_stat: cover property (O_AXI_RVALID && I_AXI_RREADY);
	cov_obs_on: cover property ($rose(O_OBS_CLK_GATE));
endmodule : pdg_ctrl

/* File: pdg_pkg.sv */
package pdg_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_POST_DIV = 8'h00;
	localparam logic [7:0] OFF_BYPASS_DIV = 8'h04;
	localparam logic [7:0] OFF_GO_CMD = 8'h08;
	localparam logic [7:0] OFF_CTRL_STAT = 8'h0c;
	localparam logic [7:0] OFF_ALIGN_SEL = 8'h10;
	localparam logic [7:0] OFF_RATIO_CHG = 8'h14;
	localparam logic [7:0] OFF_CLK_EN = 8'h18;
	localparam logic [7:0] OFF_CLK_ON = 8'h1c;
	localparam logic [7:0] OFF_OUT_STAT = 8'h20;
	localparam logic [7:0] OFF_DIV_FOUR = 8'h24;
	localparam int DIV_EN_BIT = 15;
	localparam int RATIO_W = 5;
	localparam int NUM_SYS = 9;
	localparam int SYS_FOUR_IDX = 3;
	localparam int SECOND_SYS = 5;
	localparam logic [8:0] ALIGN_RST_FIRST = 9'h01c;
	localparam logic [8:0] ALIGN_RST_SECOND = 9'h000;
	localparam int STAT_GO_BIT = 0;
	localparam int STAT_LOCK_BIT = 1;
	localparam int STAT_STABLE_BIT = 2;
	localparam int CKON_AUX_BIT = 0;
	localparam int CKON_OBS_BIT = 1;
	localparam int CKON_BP_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic en;
		logic [RATIO_W-1:0] ratio;
	} pdg_div_type;

	localparam pdg_div_type DIV_RST = '{en: 1'b1, ratio: 5'h00};

	typedef struct packed {
		logic obs_en;
		logic aux_en;
	} pdg_clk_en_type;

	typedef enum logic [2:0] {
		GO_IDLE = 3'b001,
		GO_WAIT = 3'b010,
		GO_APPLY = 3'b100
	} pdg_go_state_type;
endpackage : pdg_pkg

/* File: pdg_ctrl_bench.sv */
`timescale 1ns/1ps
module pdg_ctrl_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic pll_lock = 1'b0;
	logic osc_counting = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [8:0] sys_running = 9'h0a5;
	logic [8:0] ratio_pending = 9'h000;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] ticks;
	wire obs_gate, aux_gate, go_busy;
	wire aux_gate2;
	wire [31:0] rdata2;
	wire [1:0] bresp2, rresp2;
	wire [8:0] align_pulse;
	int err_total = 0;
	int comparisons = 0;
	int busy_n = 0;
	int b0, cnt;
	logic [8:0] seen_align = 9'h000;
	logic [7:0] offs [10] = '{pdg_pkg::OFF_POST_DIV, pdg_pkg::OFF_BYPASS_DIV,
		pdg_pkg::OFF_GO_CMD, pdg_pkg::OFF_CTRL_STAT, pdg_pkg::OFF_ALIGN_SEL,
		pdg_pkg::OFF_RATIO_CHG, pdg_pkg::OFF_CLK_EN, pdg_pkg::OFF_CLK_ON,
		pdg_pkg::OFF_OUT_STAT, pdg_pkg::OFF_DIV_FOUR};
	logic [31:0] rst_vals [10] = '{32'h8000, 32'h8000, 32'h0, 32'h4, 32'h1c,
		32'h0, 32'h1, 32'h9, 32'h0ad, 32'h8000};
	logic [31:0] rst_vals2 [10] = '{32'h8000, 32'h8000, 32'h0, 32'h4, 32'h0,
		32'h0, 32'h0, 32'h8, 32'h00d, 32'h8000};

	always #2.5 clk = ~clk;

	pdg_ctrl #(.FIRST(1'b1)) pdg_ctrl_i (
		.I_REF_CLK(clk), .I_RST_N(rst_n),
		.I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
		.I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
		.O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid),
		.I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
		.O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
		.O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .I_PLL_LOCK(pll_lock),
		.I_OSC_COUNTING(osc_counting), .I_SYS_RUNNING(sys_running),
		.I_RATIO_PENDING(ratio_pending), .O_BYPASS_CLK_EN(ticks[1]),
		.O_POST_CLK_EN(ticks[0]), .O_SYS_FOUR_CLK_EN(ticks[2]),
		.O_OBS_CLK_GATE(obs_gate), .O_AUX_CLK_GATE(aux_gate),
		.O_ALIGN_PULSE(align_pulse), .O_GO_BUSY(go_busy)
	);

	// second controller shares the bus; its handshake timing is identical
	pdg_ctrl #(.FIRST(1'b0)) pdg_ctrl_i2 (
		.I_REF_CLK(clk), .I_RST_N(rst_n),
		.I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(),
		.I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
		.O_AXI_WREADY(), .O_AXI_BRESP(bresp2), .O_AXI_BVALID(),
		.I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
		.O_AXI_ARREADY(), .O_AXI_RDATA(rdata2), .O_AXI_RRESP(rresp2),
		.O_AXI_RVALID(), .I_AXI_RREADY(rready), .I_PLL_LOCK(pll_lock),
		.I_OSC_COUNTING(osc_counting), .I_SYS_RUNNING(sys_running),
		.I_RATIO_PENDING(ratio_pending), .O_BYPASS_CLK_EN(),
		.O_POST_CLK_EN(), .O_SYS_FOUR_CLK_EN(),
		.O_OBS_CLK_GATE(), .O_AUX_CLK_GATE(aux_gate2),
		.O_ALIGN_PULSE(), .O_GO_BUSY()
	);

	// watch on the falling edge so it never races the bench's own sampling
	always @(negedge clk)
	begin
		if (go_busy === 1'b1)
			busy_n++;
		seen_align = seen_align | align_pulse;
	end

	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		bready <= 1'b0;
		if (n == 100)
		begin
			err_total++;
			end_of_test();
		end
		chk({30'h0, bresp}, {30'h0, er});
		repeat (2) @(posedge clk);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		rready <= 1'b0;
		if (n == 100)
		begin
			err_total++;
			end_of_test();
		end
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
		repeat (2) @(posedge clk);
	endtask : rd

	task count_ticks(input int sel, input int n, input int exp);
		cnt = 0;
		repeat (n)
		begin
			@(posedge clk);
			if (ticks[sel] === 1'b1)
				cnt++;
		end
		chk(cnt, exp);
	endtask : count_ticks

	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			rd(offs[i], rst_vals[i], pdg_pkg::RESP_OKAY);
			chk(rdata2, rst_vals2[i]);
			chk({30'h0, rresp2}, i == 6 ? 32'h2 : 32'h0);
		end
		chk({31'h0, aux_gate}, 32'h1);
		chk({31'h0, aux_gate2}, 32'h0);
		rd(8'h28, 32'h0, pdg_pkg::RESP_SLVERR);
		wr(8'h28, 32'h1, pdg_pkg::RESP_SLVERR);
		$display("test reset values done");

		pll_lock <= 1'b1;
		osc_counting <= 1'b1;
		sys_running <= 9'h152;
		repeat (3) @(posedge clk);
		rd(pdg_pkg::OFF_CTRL_STAT, 32'h2, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_OUT_STAT, 32'h15a, pdg_pkg::RESP_OKAY);
		chk(rdata2, 32'h01a);
		osc_counting <= 1'b0;
		$display("test status inputs done");

		wr(pdg_pkg::OFF_CLK_EN, 32'h3, pdg_pkg::RESP_OKAY);
		chk({30'h0, bresp2}, 32'h2);
		chk({31'h0, obs_gate}, 32'h1);
		rd(pdg_pkg::OFF_CLK_ON, 32'hb, pdg_pkg::RESP_OKAY);
		chk(rdata2, 32'h8);
		wr(pdg_pkg::OFF_CLK_EN, 32'h1, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_CLK_ON, 32'h9, pdg_pkg::RESP_OKAY);
		$display("test clock enables done");

		// first go applies div4 ratio 31, so the second go waits long
		wr(pdg_pkg::OFF_ALIGN_SEL, 32'hffffffff, pdg_pkg::RESP_OKAY);
		wr(pdg_pkg::OFF_DIV_FOUR, 32'h801f, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_CTRL_STAT, 32'h6, pdg_pkg::RESP_OKAY);
		wr(pdg_pkg::OFF_GO_CMD, 32'h1, pdg_pkg::RESP_OKAY);
		ratio_pending <= 9'h111;
		wr(pdg_pkg::OFF_DIV_FOUR, 32'h8003, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_CTRL_STAT, 32'h6, pdg_pkg::RESP_OKAY);
		b0 = busy_n;
		seen_align = 9'h000;
		wr(pdg_pkg::OFF_GO_CMD, 32'h1, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_CTRL_STAT, 32'h7, pdg_pkg::RESP_OKAY);
		repeat (60) @(posedge clk);
		chk({31'h0, (busy_n - b0 >= 2) && (busy_n - b0 <= 34)}, 32'h1);
		chk({23'h0, seen_align}, 32'h1ff);
		rd(pdg_pkg::OFF_CTRL_STAT, 32'h6, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_ALIGN_SEL, 32'h1ff, pdg_pkg::RESP_OKAY);
		chk(rdata2, 32'h01f);
		rd(pdg_pkg::OFF_RATIO_CHG, 32'h119, pdg_pkg::RESP_OKAY);
		chk(rdata2, 32'h019);
		rd(pdg_pkg::OFF_GO_CMD, 32'h1, pdg_pkg::RESP_OKAY);
		$display("test go operation done");

		wr(pdg_pkg::OFF_POST_DIV, 32'h8002, pdg_pkg::RESP_OKAY);
		wr(pdg_pkg::OFF_BYPASS_DIV, 32'h8004, pdg_pkg::RESP_OKAY);
		count_ticks(0, 60, 20);
		count_ticks(1, 60, 12);
		count_ticks(2, 60, 15);
		$display("test divider ratios done");

		wr(pdg_pkg::OFF_GO_CMD, 32'h0, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_GO_CMD, 32'h0, pdg_pkg::RESP_OKAY);
		rd(pdg_pkg::OFF_CTRL_STAT, 32'h6, pdg_pkg::RESP_OKAY);
		b0 = busy_n;
		wr(pdg_pkg::OFF_GO_CMD, 32'h1, pdg_pkg::RESP_OKAY);
		repeat (40) @(posedge clk);
		chk({31'h0, busy_n > b0}, 32'h1);
		chk({31'h0, go_busy}, 32'h0);
		$display("test go restart done");
		end_of_test();
	end

	initial
	begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule : pdg_ctrl_bench
